// [sac_pkg.sv]
// Purpose: constants and types for the sar converter sequencer
// Assumes: 125 MHz clk, avalon-mm register slave with 32-bit words
// Notes: register indices times four give byte addresses
// Notes on behaviour
// - clock select 00/01/10/11 gives osc/8, osc/32, osc/64, internal rc period
// - format one: right justified, upper six bits of high byte zero
// - format zero: left justified, lower six bits of low byte zero
// - config bit four reads zero, writes ignored
// - reference select one uses external reference pins, zero uses supply/ground
// - pin map 000 makes all sixteen analog, 111 all digital
// - map codes 1..6 make top n of each eight-group digital
// - on finish load result, clear go/done, set done flag
// - conversion lasts twelve bit periods from go set
// - hold capacitor stays disconnected two bit periods after conversion
// - hold capacitor is never discharged between conversions
// - four-bit channel select picks input 0 to 15 directly
// - with converter on, setting go starts; hardware clears when done
// - clearing go mid-conversion aborts, keeps result, waits two periods
package sac_pkg;
    localparam logic [7:0] SAC_IDX_CONTROL = 8'h14;
    localparam logic [7:0] SAC_IDX_CONFIG = 8'h15;
    localparam logic [7:0] SAC_IDX_RES_HIGH = 8'h16;
    localparam logic [7:0] SAC_IDX_RES_LOW = 8'h17;
    localparam logic [7:0] SAC_IDX_FLAG = 8'h18;
    localparam logic [7:0] SAC_CONFIG_RESET = 8'h00;
    localparam logic [7:0] SAC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SAC_CONFIG_MASK = 8'hef;
    localparam logic [7:0] SAC_CONTROL_MASK = 8'hf5;
    localparam int SAC_CTL_GO_BIT = 2;
    localparam int SAC_CTL_ON_BIT = 0;
    localparam int SAC_CONV_PERIODS = 12;
    localparam int SAC_GAP_PERIODS = 2;
    localparam int SAC_DIV_OSC8 = 8;
    localparam int SAC_DIV_OSC32 = 32;
    localparam int SAC_DIV_OSC64 = 64;
    localparam int SAC_RC_DIV = 250;
    typedef enum logic [3:0] {
        SAC_IDLE = 4'b0001,
        SAC_CONV = 4'b0010,
        SAC_GAP = 4'b0100,
        SAC_SPARE = 4'b1000
    } sac_state_type;
    typedef struct packed {
        logic [1:0] clock_sel;
        logic fmt;
        logic zero4;
        logic [2:0] pin_map;
        logic ref_sel;
    } sac_config_type;
endpackage

// [sac_top.sv]
// Purpose: sequencer and registers of a 10-bit sar converter
// Assumes: comparator input from analog block, rst_b asynchronous low
// Notes: registers are one byte each in the low bits of a word
`timescale 1ns/100ps
module sac_top #(
    parameter int RES_BITS = 10
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic comp_in,
    output logic [RES_BITS-1:0] dac_code,
    output logic hold_connect,
    output logic [3:0] channel_select,
    output logic reference_select,
    output logic [15:0] analog_inputs_mode,
    output logic conv_done_flag
);
    // register state
    sac_pkg::sac_config_type cfg, next_cfg;
    logic [7:0] ctl, next_ctl;
    logic [15:0] res, next_res;
    logic flag, next_flag;
    logic ack, next_ack;
    logic [31:0] next_readdata;
    sac_pkg::sac_state_type state, next_state;
    logic [7:0] div_cnt, next_div_cnt;
    logic [3:0] per_cnt, next_per_cnt;
    logic [RES_BITS-1:0] sar, next_sar;
    logic [3:0] bit_idx, next_bit_idx;
    logic [2:0] cmp_sync;
    logic tick;
    logic [7:0] div_top;
    logic wr_ctl;
    logic wr_cfg;
    logic wr_flag;
    logic [RES_BITS-1:0] trial;
    // cycle counters that the length checks lean on
    logic [11:0] conv_len, next_conv_len;
    logic [11:0] gap_len, next_gap_len;
    // comparator passes three flops; change counts when last two agree
    logic cmp_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_sync <= 3'h0;
            cmp_q <= 1'b0;
        end else begin
            cmp_sync <= {cmp_sync[1:0], comp_in};
            if (cmp_sync[2] == cmp_sync[1]) begin
                cmp_q <= cmp_sync[2];
            end
        end
    end
    // bit period divider from clock select
    always_comb begin
        case (cfg.clock_sel)
            2'b00: div_top = 8'(sac_pkg::SAC_DIV_OSC8 - 1);
            2'b01: div_top = 8'(sac_pkg::SAC_DIV_OSC32 - 1);
            2'b10: div_top = 8'(sac_pkg::SAC_DIV_OSC64 - 1);
            default: div_top = 8'(sac_pkg::SAC_RC_DIV - 1);
        endcase
    end
    assign tick = (div_cnt == div_top);
    // writes land only at the edge where waitrequest is sampled low
    assign wr_ctl = write && ack && byteenable[0] && address == sac_pkg::SAC_IDX_CONTROL;
    assign wr_cfg = write && ack && byteenable[0] && address == sac_pkg::SAC_IDX_CONFIG;
    assign wr_flag = write && ack && byteenable[0] && address == sac_pkg::SAC_IDX_FLAG;
    assign trial = sar | (RES_BITS'(1) << bit_idx);
    // sequencer and register next values
    always_comb begin
        next_cfg = cfg;
        next_ctl = ctl;
        next_res = res;
        next_flag = flag;
        next_state = state;
        next_sar = sar;
        next_bit_idx = bit_idx;
        next_per_cnt = per_cnt;
        next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
        next_ack = (read || write) && !ack;
        // cycles spent in the current conversion or gap, zero elsewhere
        next_conv_len = (state == sac_pkg::SAC_CONV) ? conv_len + 12'h001 : 12'h000;
        next_gap_len = (state == sac_pkg::SAC_GAP) ? gap_len + 12'h001 : 12'h000;
        if (wr_cfg) begin
            next_cfg = sac_pkg::sac_config_type'(writedata[7:0] & sac_pkg::SAC_CONFIG_MASK);
        end
        if (wr_ctl) begin
            next_ctl = writedata[7:0] & sac_pkg::SAC_CONTROL_MASK;
        end
        if (wr_flag && writedata[0]) begin
            next_flag = 1'b0;
        end
        case (state)
            sac_pkg::SAC_IDLE: begin
                if (ctl[sac_pkg::SAC_CTL_GO_BIT] && ctl[sac_pkg::SAC_CTL_ON_BIT]) begin
                    next_state = sac_pkg::SAC_CONV;
                    next_div_cnt = 8'h00;
                    next_per_cnt = 4'h0;
                    next_sar = '0;
                    next_bit_idx = 4'(RES_BITS - 1);
                end
            end
            sac_pkg::SAC_CONV: begin
                if (!ctl[sac_pkg::SAC_CTL_GO_BIT] || !ctl[sac_pkg::SAC_CTL_ON_BIT]) begin
                    next_state = sac_pkg::SAC_GAP;
                    next_per_cnt = 4'h0;
                    next_div_cnt = 8'h00;
                end else if (tick) begin
                    next_per_cnt = per_cnt + 4'h1;
                    if (per_cnt >= 4'h1 && per_cnt <= 4'(RES_BITS)) begin
                        next_sar = cmp_q ? trial : sar;
                        next_bit_idx = bit_idx - 4'h1;
                    end
                    if (per_cnt == 4'(sac_pkg::SAC_CONV_PERIODS - 1)) begin
                        next_state = sac_pkg::SAC_GAP;
                        next_per_cnt = 4'h0;
                        next_ctl[sac_pkg::SAC_CTL_GO_BIT] = 1'b0;
                        next_flag = 1'b1;
                        if (cfg.fmt) begin
                            next_res = {6'h00, sar};
                        end else begin
                            next_res = {sar, 6'h00};
                        end
                    end
                end
            end
            sac_pkg::SAC_GAP: begin
                if (tick) begin
                    next_per_cnt = per_cnt + 4'h1;
                    if (per_cnt == 4'(sac_pkg::SAC_GAP_PERIODS - 1)) begin
                        next_state = sac_pkg::SAC_IDLE;
                    end
                end
            end
            default: next_state = sac_pkg::SAC_IDLE;
        endcase
        // read decode
        if (address == sac_pkg::SAC_IDX_CONTROL) begin
            next_readdata = {24'h0, ctl};
        end else if (address == sac_pkg::SAC_IDX_CONFIG) begin
            next_readdata = {24'h0, cfg};
        end else if (address == sac_pkg::SAC_IDX_RES_HIGH) begin
            next_readdata = {24'h0, res[15:8]};
        end else if (address == sac_pkg::SAC_IDX_RES_LOW) begin
            next_readdata = {24'h0, res[7:0]};
        end else if (address == sac_pkg::SAC_IDX_FLAG) begin
            next_readdata = {31'h0, flag};
        end else begin
            next_readdata = 32'h0;
        end
    end
    // register all state except the comparator synchronizer flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= sac_pkg::sac_config_type'(sac_pkg::SAC_CONFIG_RESET);
            ctl <= sac_pkg::SAC_CONTROL_RESET;
            res <= 16'h0000;
            flag <= 1'b0;
            ack <= 1'b0;
            readdata <= 32'h0;
            state <= sac_pkg::SAC_IDLE;
            div_cnt <= 8'h00;
            per_cnt <= 4'h0;
            sar <= '0;
            bit_idx <= 4'h0;
            conv_len <= 12'h000;
            gap_len <= 12'h000;
        end else begin
            cfg <= next_cfg;
            ctl <= next_ctl;
            res <= next_res;
            flag <= next_flag;
            ack <= next_ack;
            readdata <= next_readdata;
            state <= next_state;
            div_cnt <= next_div_cnt;
            per_cnt <= next_per_cnt;
            sar <= next_sar;
            bit_idx <= next_bit_idx;
            conv_len <= next_conv_len;
            gap_len <= next_gap_len;
        end
    end
    // outputs; hold cap only connected while idle, never discharged
    assign waitrequest = (read || write) && !ack;
    assign hold_connect = (state == sac_pkg::SAC_IDLE);
    assign dac_code = trial;
    assign channel_select = ctl[7:4];
    assign reference_select = cfg.ref_sel;
    assign conv_done_flag = flag;
    // digital mask per pin map
    // both eight-input groups lose their top inputs alike
    // code seven must leave no analog pin at all
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            analog_inputs_mode[i] = (i < 8 - int'(cfg.pin_map)) && cfg.pin_map != 3'h7;
            analog_inputs_mode[i+8] = (i < 8 - int'(cfg.pin_map)) && cfg.pin_map != 3'h7;
        end
    end
    // assertions
    a_done_clears_go: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(flag) |-> !ctl[sac_pkg::SAC_CTL_GO_BIT] && state == sac_pkg::SAC_GAP) else $error("go not cleared");
    a_gap_no_hold: assert property (@(posedge clk) disable iff (!rst_b)
        state == sac_pkg::SAC_GAP |-> !hold_connect) else $error("hold connected in gap");
    a_cfg_bit4_zero: assert property (@(posedge clk) disable iff (!rst_b)
        !cfg.zero4) else $error("config bit four set");
    a_right_just: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(flag) && cfg.fmt |-> res[15:10] == 6'h0) else $error("right justify");
    a_left_just: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(flag) && !cfg.fmt |-> res[5:0] == 6'h0) else $error("left justify");
    // named steps of a conversion, shared by the properties below
    // go seen while idle and switched on
    sequence s_go_seen;
        state == sac_pkg::SAC_IDLE && ctl[sac_pkg::SAC_CTL_GO_BIT] && ctl[sac_pkg::SAC_CTL_ON_BIT];
    endsequence
    // last bit period ends with go still standing
    sequence s_last_tick;
        state == sac_pkg::SAC_CONV && tick && per_cnt == 4'(sac_pkg::SAC_CONV_PERIODS - 1)
            && ctl[sac_pkg::SAC_CTL_GO_BIT] && ctl[sac_pkg::SAC_CTL_ON_BIT];
    endsequence
    // software pulled go or on during a conversion
    sequence s_abort_seen;
        state == sac_pkg::SAC_CONV && (!ctl[sac_pkg::SAC_CTL_GO_BIT] || !ctl[sac_pkg::SAC_CTL_ON_BIT]);
    endsequence
    // recovery gap about to hand back to acquisition
    sequence s_gap_exit;
        state == sac_pkg::SAC_GAP && next_state == sac_pkg::SAC_IDLE;
    endsequence
    a_abort_keeps: assert property (@(posedge clk) disable iff (!rst_b)
        s_abort_seen |=> $stable(res) && $stable(flag))
        else $error("abort changed result");
    a_start_conv: assert property (@(posedge clk) disable iff (!rst_b)
        s_go_seen |=> state == sac_pkg::SAC_CONV) else $error("no start");
    a_map_digital: assert property (@(posedge clk) disable iff (!rst_b)
        cfg.pin_map == 3'h7 |-> analog_inputs_mode == 16'h0000)
        else $error("mapping");
    a_map_analog: assert property (@(posedge clk) disable iff (!rst_b)
        cfg.pin_map == 3'h0 |-> analog_inputs_mode == 16'hffff)
        else $error("all analog mapping");
    a_finish_loads: assert property (@(posedge clk) disable iff (!rst_b)
        s_last_tick |=> flag && !ctl[sac_pkg::SAC_CTL_GO_BIT] && state == sac_pkg::SAC_GAP)
        else $error("finish did not load");
    a_conv_length: assert property (@(posedge clk) disable iff (!rst_b)
        s_last_tick |-> conv_len == 12'(sac_pkg::SAC_CONV_PERIODS) * (12'(div_top) + 12'h001) - 12'h001)
        else $error("conversion length");
    a_gap_length: assert property (@(posedge clk) disable iff (!rst_b)
        s_gap_exit |-> gap_len == 12'(sac_pkg::SAC_GAP_PERIODS) * (12'(div_top) + 12'h001) - 12'h001)
        else $error("gap length");
    a_abort_to_gap: assert property (@(posedge clk) disable iff (!rst_b)
        s_abort_seen |=> state == sac_pkg::SAC_GAP)
        else $error("abort did not enter gap");
    a_res_held: assert property (@(posedge clk) disable iff (!rst_b)
        state != sac_pkg::SAC_CONV |=> $stable(res))
        else $error("result changed outside finish");
    a_conv_no_hold: assert property (@(posedge clk) disable iff (!rst_b)
        state == sac_pkg::SAC_CONV |-> !hold_connect)
        else $error("hold connected in conversion");
    a_ref_route: assert property (@(posedge clk) disable iff (!rst_b)
        reference_select == cfg.ref_sel)
        else $error("reference route");
    a_msb_first: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(state == sac_pkg::SAC_CONV) |=> bit_idx == 4'(RES_BITS - 1)) else $error("msb first");
endmodule

// [sac_analog_src.sv]
// Purpose: analog source and comparator model facing the converter
// Assumes: comp_in high when held sample is at or above the trial code
// Notes: sample tracks the input only while the hold switch is closed
`timescale 1ns/100ps
module sac_analog_src (
    input wire logic clk,
    input wire logic [9:0] level,
    input wire logic hold_connect,
    input wire logic [9:0] dac_code,
    output logic comp_in
);
    logic [9:0] held = 10'h000;
    // sample kept, never discharged, while switch open
    always @(posedge clk) begin
        if (hold_connect) held <= level;
    end
    // comparator decision against trial code
    assign comp_in = (held >= dac_code);
endmodule

// [testbench.sv]
// Purpose: self-checking bench for the converter sequencer
// Assumes: avalon master with bytes in the low lane
// Notes: bit period counts derived from the clock select table
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, comp_in;
    logic [7:0] address = 8'h00, q, hi, lo;
    logic [31:0] writedata = 32'h0, readdata;
    logic waitrequest, hold_connect, reference_select, conv_done_flag;
    logic [9:0] dac_code, lvl [16];
    logic [3:0] channel_select;
    logic [15:0] analog_inputs_mode;
    int mismatches = 0, checks_done = 0, cyc = 0, n;
    logic [7:0] cfg_row [8] = '{8'h10, 8'h43, 8'ha4, 8'he7, 8'h19, 8'h5b, 8'hbd, 8'hff};
    logic [15:0] mode_row [8] = '{16'hffff, 16'h7f7f, 16'h3f3f, 16'h1f1f, 16'h0f0f, 16'h0707, 16'h0303, 16'h0000};
    int div_row [4] = '{8, 32, 64, sac_pkg::SAC_RC_DIV};
    sac_top i_sac_top (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
        .comp_in(comp_in), .dac_code(dac_code), .hold_connect(hold_connect),
        .channel_select(channel_select), .reference_select(reference_select),
        .analog_inputs_mode(analog_inputs_mode), .conv_done_flag(conv_done_flag));
    sac_analog_src i_sac_analog_src (.clk(clk), .level(lvl[channel_select]), .hold_connect(hold_connect),
        .dac_code(dac_code), .comp_in(comp_in));
    // clock
    initial begin
        forever #4 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches = mismatches + 1;
            give_verdict();
        end
    end
    task give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon access, held until waitrequest low
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= {24'h0, d};
        do @(posedge clk); while (waitrequest !== 1'b0);
        r = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
    endtask
    // one full conversion on channel ch
    task conv(input logic [7:0] cfg, input logic [3:0] ch, input int div);
        bus(1, 8'h15, cfg, q);
        bus(1, 8'h14, {ch, 4'h1}, q);
        @(negedge clk);
        chk(channel_select, ch);
        repeat (4) @(negedge clk);
        bus(1, 8'h14, {ch, 4'h5}, q);
        n = 0;
        while (conv_done_flag !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n = n + 1;
        end
        chk(n >= 12 * div - 3 && n <= 12 * div + 3, 1);
        chk(hold_connect, 0);
        bus(0, 8'h14, 8'h00, q);
        chk(q, {ch, 4'h1});
        bus(0, 8'h16, 8'h00, hi);
        bus(0, 8'h17, 8'h00, lo);
        if (cfg[5]) chk({hi, lo}, {6'h0, lvl[ch]});
        else chk({hi, lo}, {lvl[ch], 6'h0});
        bus(1, 8'h18, 8'h01, q);
        bus(0, 8'h18, 8'h00, q);
        chk(q, 0);
        repeat (2 * div + 4) @(negedge clk);
        chk(hold_connect, 1);
    endtask
    initial begin
        for (int i = 0; i < 16; i++) lvl[i] = 10'(i * 61 + 7);
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        bus(0, 8'h15, 8'h00, q);
        chk(q, 0);
        bus(0, 8'h30, 8'h00, q);
        chk(q, 0);
        // configuration rows
        for (int i = 0; i < 8; i++) begin
            bus(1, 8'h15, cfg_row[i], q);
            bus(0, 8'h15, 8'h00, q);
            chk(q, cfg_row[i] & 8'hef);
            chk(analog_inputs_mode, mode_row[i]);
            chk(reference_select, cfg_row[i][0]);
        end
        // every clock select, both formats
        for (int i = 0; i < 4; i++) conv({2'(i), i[0], 5'h0}, 4'(i * 5), div_row[i]);
        conv(8'h20, 4'hf, 8);
        // abort mid-conversion keeps old result
        lvl[15] = 10'h2aa;
        bus(1, 8'h14, 8'hf5, q);
        repeat (40) @(negedge clk);
        bus(1, 8'h14, 8'hf1, q);
        repeat (200) @(negedge clk);
        chk(conv_done_flag, 0);
        chk(hold_connect, 1);
        bus(0, 8'h17, 8'h00, q);
        chk(q, lo);
        // mid-run reset during a conversion clears every register
        bus(1, 8'h15, 8'h27, q);
        bus(1, 8'h14, 8'h35, q);
        repeat (20) @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(conv_done_flag, 0);
        chk(hold_connect, 1);
        chk(analog_inputs_mode, 16'hffff);
        chk(reference_select, 0);
        bus(0, 8'h14, 8'h00, q);
        chk(q, 0);
        bus(0, 8'h16, 8'h00, q);
        chk(q, 0);
        give_verdict();
    end
endmodule
